// [common/cse_consts.svh]
// constants of the configuration store command engine
// assumes: included by the package and both link ends
// How it works
// - cmd 01h copies live settings into EEPROM
// - cmd 02h restores factory image, live untouched
// - cmd 03h followed by 146 bytes plus checksum
// - checksum is XOR of bytes 00h-91h
// - bad checksum or short block: NAK, keep EEPROM
// - new power-up image leaves live settings alone
// - image starts with five 8-byte port groups
// - drive modes from 28h, seven bytes per port
// - PWMs from 60h, divider 90h, enable 91h
// - cmd 04h reads stored image plus checksum
// - cmd 05h image write, NAK drops bad image
// - good live image applies at once
// - cmd 06h reads live image plus checksum
// - cmd 07h reloads live from stored defaults
// - commands arrive at register address 30h
// - startup uses factory image, flagged: reset clears the user-valid flag
// - reload order is not to be relied on
`ifndef CSE_CONSTS_SVH
`define CSE_CONSTS_SVH
`define CSE_IMG_LEN 146
`define CSE_IMG_LEN_B 8'h92
`define CSE_CMD_REG 8'h30
`define CSE_CMD_STORE 8'h01
`define CSE_CMD_FACTORY 8'h02
`define CSE_CMD_WR_POR 8'h03
`define CSE_CMD_RD_POR 8'h04
`define CSE_CMD_WR_LIVE 8'h05
`define CSE_CMD_RD_LIVE 8'h06
`define CSE_CMD_RECONF 8'h07
`define CSE_OFS_OUT 8'h00
`define CSE_OFS_MASK 8'h08
`define CSE_OFS_PWMSEL 8'h10
`define CSE_OFS_INV 8'h18
`define CSE_OFS_DIR 8'h20
`define CSE_OFS_DRIVE 8'h28
`define CSE_DRIVE_STRIDE 8'h07
`define CSE_OFS_PWM 8'h60
`define CSE_PWM_STRIDE 8'h03
`define CSE_OFS_DIV 8'h90
`define CSE_OFS_EN 8'h91
`define CSE_FACT_PULLUP 8'hFF
`define CSE_FACT_DIV 8'hFF
`define CSE_SRC_FACTORY 4'hF
`define CSE_SRC_USER 4'h0
`define CSE_FIFO_DEPTH 16
`define CSE_FIFO_WIDTH 9
`endif

// [common/cse_pkg.sv]
// types shared by both ends of the command engine link
// assumes: cse_consts.svh on the include path
`include "cse_consts.svh"
package cse_pkg;
  typedef logic [`CSE_IMG_LEN-1:0][7:0] cse_img_t;
  typedef enum logic [2:0] {
    D_BOOT = 3'h0,
    D_ADDR = 3'h1,
    D_CMD = 3'h3,
    D_DATA = 3'h2,
    D_SKIP = 3'h6
  } cse_dev_st_e;
  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_ADDR = 3'h1,
    H_CMD = 3'h3,
    H_DATA = 3'h2,
    H_CRC = 3'h6,
    H_WAIT = 3'h7,
    H_RREQ = 3'h5,
    H_RWAIT = 3'h4
  } cse_host_st_e;
endpackage : cse_pkg

// [common/cse_link_if.sv]
// byte link between the bus master end and the device end
// assumes: both ends run on one shared clock
`timescale 1ns/100ps
`default_nettype none
interface cse_link_if;
  logic h2d_valid;
  logic h2d_ready;
  logic h2d_last;
  logic [7:0] h2d_data;
  logic rd_req;
  logic rd_valid;
  logic [7:0] rd_data;
  logic done;
  logic nak;
  modport dev (
    input h2d_valid, h2d_last, h2d_data, rd_req,
    output h2d_ready, rd_valid, rd_data, done, nak
  );
  modport host (
    output h2d_valid, h2d_last, h2d_data, rd_req,
    input h2d_ready, rd_valid, rd_data, done, nak
  );
endinterface : cse_link_if
`default_nettype wire

// [hdl/cse_device.sv]
// device end: command register, image store, live settings
// assumes: master end on the link, same clock, sync reset
`timescale 1ns/100ps
`default_nettype none
`include "cse_consts.svh"

module cse_fifo #(
  parameter int W = `CSE_FIFO_WIDTH,
  parameter int DEPTH = `CSE_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready_o = (cnt_r != AW'(0) + (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rp_r];

  always_comb begin
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    wp_nxt = push ? wp_r + AW'(1) : wp_r;
    rp_nxt = pop ? rp_r + AW'(1) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end
endmodule : cse_fifo

module cse_device (
  // clock and reset
  input wire logic CLK_I,
  input wire logic SRST_I,
  // link to the bus master end
  cse_link_if.dev LNK,
  // live settings and status
  output cse_pkg::cse_img_t LIVE_CFG_O,
  output logic [3:0] DEFAULTS_SOURCE_O,
  output logic EE_USER_VALID_O
);
  cse_pkg::cse_dev_st_e st_r, st_nxt;
  cse_pkg::cse_img_t live_r, live_nxt, ee_r, ee_nxt, stage_r, stage_nxt;
  cse_pkg::cse_img_t ee_view;
  logic [7:0] cnt_r, cnt_nxt, sum_r, sum_nxt, cmd_r, cmd_nxt;
  logic bad_r, bad_nxt, ee_ok_r, ee_ok_nxt, done_r, done_nxt;
  logic nak_r, nak_nxt;
  logic [3:0] src_r, src_nxt;
  logic [7:0] rd_idx_r, rd_idx_nxt, rd_sum_r, rd_sum_nxt;
  logic [7:0] rd_data_r, rd_data_nxt;
  logic rd_ee_r, rd_ee_nxt, rd_valid_r, rd_valid_nxt;
  logic f_valid, f_ready, f_last;
  logic [7:0] f_data;
  logic [7:0] rd_byte;

  function automatic logic [7:0] factory_byte(input logic [7:0] idx);
    logic [7:0] rel;
    rel = idx - `CSE_OFS_DRIVE;
    if (idx == `CSE_OFS_DIV) begin
      return `CSE_FACT_DIV;
    end
    if (idx >= `CSE_OFS_DRIVE && idx < `CSE_OFS_PWM &&
        rel % `CSE_DRIVE_STRIDE == 8'h00) begin
      return `CSE_FACT_PULLUP; // pull-up default per port
    end
    return 8'h00;
  endfunction : factory_byte

  cse_fifo #(
    .W(`CSE_FIFO_WIDTH),
    .DEPTH(`CSE_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .in_valid_i(LNK.h2d_valid),
    .in_data_i({LNK.h2d_last, LNK.h2d_data}),
    .in_ready_o(LNK.h2d_ready),
    .out_valid_o(f_valid),
    .out_data_o({f_last, f_data}),
    .out_ready_i(f_ready)
  );

  // engine stalls the fifo only while booting
  assign f_ready = (st_r != cse_pkg::D_BOOT);

  // stored defaults as seen by readers: factory when unset
  always_comb begin
    for (int i = 0; i < `CSE_IMG_LEN; i++) begin
      ee_view[i] = ee_ok_r ? ee_r[i] : factory_byte(8'(i));
    end
  end

  always_comb begin
    st_nxt = st_r;
    live_nxt = live_r;
    ee_nxt = ee_r;
    stage_nxt = stage_r;
    cnt_nxt = cnt_r;
    sum_nxt = sum_r;
    cmd_nxt = cmd_r;
    bad_nxt = bad_r;
    ee_ok_nxt = ee_ok_r;
    src_nxt = src_r;
    done_nxt = 1'b0;
    nak_nxt = nak_r;
    case (st_r)
      cse_pkg::D_BOOT: begin
        live_nxt = ee_view; // all bytes at once
        src_nxt = ee_ok_r ? `CSE_SRC_USER : `CSE_SRC_FACTORY;
        st_nxt = cse_pkg::D_ADDR;
      end
      cse_pkg::D_ADDR: begin
        if (f_valid) begin
          bad_nxt = 1'b0;
          if (f_last) begin
            done_nxt = 1'b1;
            nak_nxt = 1'b0;
          end else if (f_data == `CSE_CMD_REG) begin
            st_nxt = cse_pkg::D_CMD;
          end else begin
            st_nxt = cse_pkg::D_SKIP;
          end
        end
      end
      cse_pkg::D_CMD: begin
        if (f_valid) begin
          cmd_nxt = f_data;
          cnt_nxt = 8'h00;
          sum_nxt = 8'h00;
          if (f_last) begin
            done_nxt = 1'b1;
            nak_nxt = 1'b0;
            st_nxt = cse_pkg::D_ADDR;
            case (f_data)
              `CSE_CMD_STORE: begin
                ee_nxt = live_r;
                ee_ok_nxt = 1'b1;
              end
              `CSE_CMD_FACTORY: ee_ok_nxt = 1'b0;
              `CSE_CMD_RECONF: begin
                live_nxt = ee_view;
                src_nxt = ee_ok_r ? `CSE_SRC_USER : `CSE_SRC_FACTORY;
              end
              `CSE_CMD_RD_POR, `CSE_CMD_RD_LIVE: nak_nxt = 1'b0;
              default: nak_nxt = 1'b1; // image cmd with no data, or unknown cmd
            endcase
          end else if (f_data == `CSE_CMD_WR_POR ||
                       f_data == `CSE_CMD_WR_LIVE) begin
            st_nxt = cse_pkg::D_DATA;
          end else begin
            bad_nxt = 1'b1;
            st_nxt = cse_pkg::D_SKIP;
          end
        end
      end
      cse_pkg::D_DATA: begin
        if (f_valid) begin
          if (cnt_r != `CSE_IMG_LEN_B) begin
            stage_nxt[cnt_r] = f_data;
            sum_nxt = sum_r ^ f_data;
            cnt_nxt = cnt_r + 8'h01;
            if (f_last) begin
              done_nxt = 1'b1;
              nak_nxt = 1'b1; // short block
              st_nxt = cse_pkg::D_ADDR;
            end
          end else if (f_last) begin
            done_nxt = 1'b1;
            nak_nxt = (f_data != sum_r);
            st_nxt = cse_pkg::D_ADDR;
            if (f_data == sum_r) begin
              if (cmd_r == `CSE_CMD_WR_POR) begin
                ee_nxt = stage_r; // live kept
                ee_ok_nxt = 1'b1;
              end else begin
                live_nxt = stage_r;
              end
            end
          end else begin
            bad_nxt = 1'b1; // overlong block dropped
            st_nxt = cse_pkg::D_SKIP;
          end
        end
      end
      cse_pkg::D_SKIP: begin
        if (f_valid && f_last) begin
          done_nxt = 1'b1;
          nak_nxt = bad_r;
          st_nxt = cse_pkg::D_ADDR;
        end
      end
      default: st_nxt = cse_pkg::D_BOOT;
    endcase
  end

  // read side: byte pointer, source select, running checksum
  always_comb begin
    rd_idx_nxt = rd_idx_r;
    rd_sum_nxt = rd_sum_r;
    rd_ee_nxt = rd_ee_r;
    rd_valid_nxt = 1'b0;
    rd_data_nxt = rd_data_r;
    if (rd_idx_r < `CSE_IMG_LEN_B) begin
      rd_byte = rd_ee_r ? ee_view[rd_idx_r] : live_r[rd_idx_r];
    end else if (rd_idx_r == `CSE_IMG_LEN_B) begin
      rd_byte = rd_sum_r;
    end else begin
      rd_byte = 8'h00;
    end
    if (st_r == cse_pkg::D_CMD && f_valid && f_last &&
        (f_data == `CSE_CMD_RD_POR || f_data == `CSE_CMD_RD_LIVE)) begin
      rd_idx_nxt = 8'h00;
      rd_sum_nxt = 8'h00;
      rd_ee_nxt = (f_data == `CSE_CMD_RD_POR);
    end else if (LNK.rd_req) begin
      rd_valid_nxt = 1'b1;
      rd_data_nxt = rd_byte;
      if (rd_idx_r < `CSE_IMG_LEN_B) begin
        rd_sum_nxt = rd_sum_r ^ rd_byte;
      end
      if (rd_idx_r != 8'hFF) begin
        rd_idx_nxt = rd_idx_r + 8'h01;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      st_r <= cse_pkg::D_BOOT;
      live_r <= '0;
      cnt_r <= 8'h00;
      sum_r <= 8'h00;
      cmd_r <= 8'h00;
      bad_r <= 1'b0;
      ee_ok_r <= 1'b0;
      src_r <= `CSE_SRC_FACTORY;
      done_r <= 1'b0;
      nak_r <= 1'b0;
      rd_idx_r <= 8'h00;
      rd_sum_r <= 8'h00;
      rd_ee_r <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_data_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      live_r <= live_nxt;
      cnt_r <= cnt_nxt;
      sum_r <= sum_nxt;
      cmd_r <= cmd_nxt;
      bad_r <= bad_nxt;
      ee_ok_r <= ee_ok_nxt;
      src_r <= src_nxt;
      done_r <= done_nxt;
      nak_r <= nak_nxt;
      rd_idx_r <= rd_idx_nxt;
      rd_sum_r <= rd_sum_nxt;
      rd_ee_r <= rd_ee_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  // image storage keeps its content across reset
  always_ff @(posedge CLK_I) begin
    ee_r <= ee_nxt;
    stage_r <= stage_nxt;
  end

  assign LNK.done = done_r;
  assign LNK.nak = nak_r;
  assign LNK.rd_valid = rd_valid_r;
  assign LNK.rd_data = rd_data_r;
  assign LIVE_CFG_O = live_r;
  assign DEFAULTS_SOURCE_O = src_r;
  assign EE_USER_VALID_O = ee_ok_r;
endmodule : cse_device
`default_nettype wire

// [hdl/cse_host.sv]
// master end: turns one user operation into link traffic
// assumes: device end on the link, same clock, sync reset
`timescale 1ns/100ps
`default_nettype none
`include "cse_consts.svh"

module cse_host (
  // clock and reset
  input wire logic CLK_I,
  input wire logic SRST_I,
  // operation request
  input wire logic OP_VALID_I,
  input wire logic [7:0] OP_CODE_I,
  output logic OP_READY_O,
  // image bytes to send
  input wire logic IMG_VALID_I,
  input wire logic [7:0] IMG_DATA_I,
  output logic IMG_READY_O,
  // bytes read back and result
  output logic RD_VALID_O,
  output logic [7:0] RD_DATA_O,
  output logic DONE_O,
  output logic NAK_O,
  // link to the device end
  cse_link_if.host LNK
);
  cse_pkg::cse_host_st_e st_r, st_nxt;
  logic [7:0] op_r, op_nxt, cnt_r, cnt_nxt, sum_r, sum_nxt;
  logic [7:0] data_r, data_nxt, rdd_r, rdd_nxt;
  logic val_r, val_nxt, last_r, last_nxt, req_r, req_nxt;
  logic img_rdy_r, img_rdy_nxt, rdv_r, rdv_nxt;
  logic done_r, done_nxt, nak_r, nak_nxt, opr_r, opr_nxt;
  logic is_img_wr, is_rd;

  always_comb begin
    is_img_wr = (op_r == `CSE_CMD_WR_POR || op_r == `CSE_CMD_WR_LIVE);
    is_rd = (op_r == `CSE_CMD_RD_POR || op_r == `CSE_CMD_RD_LIVE);
    st_nxt = st_r;
    op_nxt = op_r;
    cnt_nxt = cnt_r;
    sum_nxt = sum_r;
    data_nxt = data_r;
    val_nxt = val_r;
    last_nxt = last_r;
    req_nxt = 1'b0;
    img_rdy_nxt = img_rdy_r;
    rdv_nxt = 1'b0;
    rdd_nxt = rdd_r;
    done_nxt = 1'b0;
    nak_nxt = nak_r;
    case (st_r)
      cse_pkg::H_IDLE: begin
        if (OP_VALID_I) begin
          op_nxt = OP_CODE_I;
          data_nxt = `CSE_CMD_REG;
          last_nxt = 1'b0;
          val_nxt = 1'b1;
          st_nxt = cse_pkg::H_ADDR;
        end
      end
      cse_pkg::H_ADDR: begin
        if (LNK.h2d_ready) begin
          data_nxt = op_r;
          last_nxt = !is_img_wr;
          st_nxt = cse_pkg::H_CMD;
        end
      end
      cse_pkg::H_CMD: begin
        if (LNK.h2d_ready) begin
          val_nxt = 1'b0;
          cnt_nxt = 8'h00;
          sum_nxt = 8'h00;
          img_rdy_nxt = is_img_wr;
          st_nxt = is_img_wr ? cse_pkg::H_DATA : cse_pkg::H_WAIT;
        end
      end
      cse_pkg::H_DATA: begin
        if (val_r) begin
          if (LNK.h2d_ready) begin
            if (cnt_r == `CSE_IMG_LEN_B) begin
              data_nxt = sum_r; // checksum closes block
              last_nxt = 1'b1;
              st_nxt = cse_pkg::H_CRC;
            end else begin
              val_nxt = 1'b0;
              img_rdy_nxt = 1'b1;
            end
          end
        end else if (img_rdy_r && IMG_VALID_I) begin
          data_nxt = IMG_DATA_I;
          val_nxt = 1'b1;
          img_rdy_nxt = 1'b0;
          sum_nxt = sum_r ^ IMG_DATA_I;
          cnt_nxt = cnt_r + 8'h01;
        end
      end
      cse_pkg::H_CRC: begin
        if (LNK.h2d_ready) begin
          val_nxt = 1'b0;
          st_nxt = cse_pkg::H_WAIT;
        end
      end
      cse_pkg::H_WAIT: begin
        if (LNK.done) begin
          if (is_rd && !LNK.nak) begin
            cnt_nxt = 8'h00;
            sum_nxt = 8'h00;
            st_nxt = cse_pkg::H_RREQ;
          end else begin
            done_nxt = 1'b1;
            nak_nxt = LNK.nak;
            st_nxt = cse_pkg::H_IDLE;
          end
        end
      end
      cse_pkg::H_RREQ: begin
        req_nxt = 1'b1;
        st_nxt = cse_pkg::H_RWAIT;
      end
      cse_pkg::H_RWAIT: begin
        if (LNK.rd_valid) begin
          rdv_nxt = 1'b1;
          rdd_nxt = LNK.rd_data;
          cnt_nxt = cnt_r + 8'h01;
          if (cnt_r == `CSE_IMG_LEN_B) begin
            done_nxt = 1'b1;
            nak_nxt = (LNK.rd_data != sum_r);
            st_nxt = cse_pkg::H_IDLE;
          end else begin
            sum_nxt = sum_r ^ LNK.rd_data;
            st_nxt = cse_pkg::H_RREQ;
          end
        end
      end
      default: st_nxt = cse_pkg::H_IDLE;
    endcase
    opr_nxt = (st_nxt == cse_pkg::H_IDLE);
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      st_r <= cse_pkg::H_IDLE;
      op_r <= 8'h00;
      cnt_r <= 8'h00;
      sum_r <= 8'h00;
      data_r <= 8'h00;
      val_r <= 1'b0;
      last_r <= 1'b0;
      req_r <= 1'b0;
      img_rdy_r <= 1'b0;
      rdv_r <= 1'b0;
      rdd_r <= 8'h00;
      done_r <= 1'b0;
      nak_r <= 1'b0;
      opr_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      cnt_r <= cnt_nxt;
      sum_r <= sum_nxt;
      data_r <= data_nxt;
      val_r <= val_nxt;
      last_r <= last_nxt;
      req_r <= req_nxt;
      img_rdy_r <= img_rdy_nxt;
      rdv_r <= rdv_nxt;
      rdd_r <= rdd_nxt;
      done_r <= done_nxt;
      nak_r <= nak_nxt;
      opr_r <= opr_nxt;
    end
  end

  assign LNK.h2d_valid = val_r;
  assign LNK.h2d_data = data_r;
  assign LNK.h2d_last = last_r;
  assign LNK.rd_req = req_r;
  assign OP_READY_O = opr_r;
  assign IMG_READY_O = img_rdy_r;
  assign RD_VALID_O = rdv_r;
  assign RD_DATA_O = rdd_r;
  assign DONE_O = done_r;
  assign NAK_O = nak_r;
endmodule : cse_host
`default_nettype wire

// [testbench/cse_link_asserts.sv]
// assertions on the byte link between the master end and the device end
// assumes: instantiated in tb beside the link interface, one clock
`timescale 1ns/100ps
`default_nettype none
module cse_link_asserts (
  // clock and reset
  input wire logic CLK_I,
  input wire logic SRST_I,
  // link signals
  input wire logic h2d_valid,
  input wire logic h2d_ready,
  input wire logic h2d_last,
  input wire logic [7:0] h2d_data,
  input wire logic rd_req,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic done,
  input wire logic nak
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  logic [7:0] cnt_r, adr_r, cmd_r, x_r, s_cnt_r, s_adr_r, s_cmd_r;
  logic s_bad_r;
  logic take;
  logic s_img;
  assign take = h2d_valid && h2d_ready;
  assign s_img = s_cmd_r == 8'h03 || s_cmd_r == 8'h05;
  // snapshot of each write transaction, taken on its last byte
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      cnt_r <= 8'h00;
      x_r <= 8'h00;
    end else if (take) begin
      cnt_r <= h2d_last ? 8'h00 : cnt_r + 8'h01;
      if (cnt_r == 8'h00) adr_r <= h2d_data;
      if (cnt_r == 8'h01) cmd_r <= h2d_data;
      x_r <= h2d_last ? 8'h00 :
        (cnt_r >= 8'h02 && cnt_r < 8'h94) ? x_r ^ h2d_data : x_r;
      if (h2d_last) begin
        s_cnt_r <= cnt_r + 8'h01;
        s_adr_r <= (cnt_r == 8'h00) ? h2d_data : adr_r;
        s_cmd_r <= (cnt_r == 8'h01) ? h2d_data : cmd_r;
        s_bad_r <= x_r != h2d_data;
      end
    end
  end
  a_rd_answer: assert property (rd_req |=> rd_valid)
    else $error("read request not answered next cycle");
  a_rd_unasked: assert property (rd_valid |-> $past(rd_req))
    else $error("read byte without request");
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_byte_held: assert property (
    h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
    else $error("offered byte dropped or changed");
  a_done_after_last: assert property (
    take && h2d_last |-> ##[2:40] done)
    else $error("no done after last byte");
  a_img_crc: assert property (
    done && s_adr_r == 8'h30 && s_img && s_cnt_r == 8'h95
    |-> nak == s_bad_r)
    else $error("image nak does not match checksum");
  a_short_img: assert property (
    done && s_adr_r == 8'h30 && s_img && s_cnt_r >= 8'h02 &&
    s_cnt_r != 8'h95 |-> nak)
    else $error("wrong length image acknowledged");
  a_foreign_addr: assert property (
    done && s_adr_r != 8'h30 |-> !nak)
    else $error("nak for other register address");
  a_cmd_ack: assert property (
    done && s_adr_r == 8'h30 && s_cnt_r == 8'h02 &&
    s_cmd_r inside {8'h01, 8'h02, 8'h04, 8'h06, 8'h07} |-> !nak)
    else $error("plain command refused");
  a_bad_cmd: assert property (
    done && s_adr_r == 8'h30 && s_cnt_r == 8'h02 &&
    !(s_cmd_r inside {8'h01, 8'h02, 8'h04, 8'h06, 8'h07}) |-> nak)
    else $error("unknown command acknowledged");
  a_nak_held: assert property (!done |-> nak == $past(nak))
    else $error("nak changed without done");
endmodule : cse_link_asserts
`default_nettype wire

// [testbench/tb.sv]
// testbench: both link ends, byte model, raw driver on a second device
// assumes: package, interface, design and checker compiled first
`timescale 1ns/100ps
`default_nettype none
`include "cse_consts.svh"
module tb;
  logic CLK_I = 1'b0;
  logic SRST_I = 1'b1;
  logic op_valid = 1'b0;
  logic [7:0] op_code = 8'h00;
  logic img_valid = 1'b0;
  logic [7:0] img_data = 8'h00;
  logic img_ready, rd_v, done, nak, op_ready, eev, eev_b;
  logic [7:0] rd_d;
  logic [3:0] src, src_b;
  cse_pkg::cse_img_t live, live_b;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] rs = 32'h4539;
  logic [7:0] img[146], fac[146], stored[146], livem[146];
  logic [7:0] rq[$];
  bit dn, nk, dn2, nk2;
  cse_link_if lnk();
  cse_link_if lnk2();
  always #5 CLK_I = ~CLK_I;
  cse_host i_cse_host (.CLK_I(CLK_I), .SRST_I(SRST_I),
    .OP_VALID_I(op_valid), .OP_CODE_I(op_code), .OP_READY_O(op_ready),
    .IMG_VALID_I(img_valid), .IMG_DATA_I(img_data),
    .IMG_READY_O(img_ready), .RD_VALID_O(rd_v), .RD_DATA_O(rd_d),
    .DONE_O(done), .NAK_O(nak), .LNK(lnk));
  cse_device i_cse_device (.CLK_I(CLK_I), .SRST_I(SRST_I), .LNK(lnk),
    .LIVE_CFG_O(live), .DEFAULTS_SOURCE_O(src), .EE_USER_VALID_O(eev));
  cse_device i_cse_device_b (.CLK_I(CLK_I), .SRST_I(SRST_I), .LNK(lnk2),
    .LIVE_CFG_O(live_b), .DEFAULTS_SOURCE_O(src_b),
    .EE_USER_VALID_O(eev_b));
  cse_link_asserts i_cse_link_asserts (.CLK_I(CLK_I), .SRST_I(SRST_I),
    .h2d_valid(lnk.h2d_valid), .h2d_ready(lnk.h2d_ready),
    .h2d_last(lnk.h2d_last), .h2d_data(lnk.h2d_data), .rd_req(lnk.rd_req),
    .rd_valid(lnk.rd_valid), .rd_data(lnk.rd_data), .done(lnk.done),
    .nak(lnk.nak));
  function automatic logic [7:0] xb();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction : xb
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic chk_img(string nm, logic [7:0] e[146], cse_pkg::cse_img_t v);
    for (int i = 0; i < 146; i++) chk(nm, e[i], v[i]);
  endtask : chk_img
  task automatic chk_rd(logic [7:0] e[146]);
    logic [7:0] x = 8'h00;
    chk("read count", 147, rq.size());
    for (int i = 0; i < 146; i++) begin
      chk("read byte", e[i], rq[i]);
      x ^= e[i];
    end
    chk("read checksum", x, rq[146]);
  endtask : chk_rd
  task automatic feed();
    int k = 0;
    bit r;
    while (k < 146) begin
      img_valid = 1'b1;
      img_data = img[k];
      r = img_ready;
      @(negedge CLK_I);
      if (r) k++;
    end
    img_valid = 1'b0;
  endtask : feed
  // one user operation through the master end
  task automatic op(logic [7:0] c, bit en = 1'b0);
    int t = 0;
    bit rd;
    rd = (c == `CSE_CMD_RD_POR || c == `CSE_CMD_RD_LIVE);
    while (op_ready !== 1'b1) @(negedge CLK_I);
    rq.delete();
    dn = 0;
    op_valid = 1'b1;
    op_code = c;
    if (c == `CSE_CMD_WR_POR || c == `CSE_CMD_WR_LIVE) fork feed(); join_none
    @(negedge CLK_I);
    op_valid = 1'b0;
    while (!(rd ? rq.size() == 147 : dn) && t < 3000) begin
      @(negedge CLK_I);
      t++;
    end
    chk("op finished", 1, t < 3000);
    chk("op nak", en, nk);
    $display("test op %0h done", c);
  endtask : op
  // raw write on the second link, optionally with a broken checksum
  task automatic raw(logic [7:0] a, logic [7:0] c, int n, bit badc);
    logic [7:0] b[$];
    logic [7:0] x = 8'h00;
    bit r;
    b = {a, c};
    for (int i = 0; i < n; i++) begin
      b.push_back(img[i]);
      x ^= img[i];
    end
    if (n > 0) b.push_back(x ^ {7'h00, badc});
    dn2 = 0;
    foreach (b[i]) begin
      lnk2.h2d_valid = 1'b1;
      lnk2.h2d_data = b[i];
      lnk2.h2d_last = (i == b.size() - 1);
      do begin
        r = lnk2.h2d_ready;
        @(negedge CLK_I);
      end while (!r);
    end
    lnk2.h2d_valid = 1'b0;
    lnk2.h2d_last = 1'b0;
    repeat (60) if (!dn2) @(negedge CLK_I);
    chk("raw done", 1, dn2);
  endtask : raw
  task automatic rnd_img();
    for (int i = 0; i < 146; i++) img[i] = xb();
  endtask : rnd_img
  always @(posedge CLK_I) begin
    cyc <= cyc + 1;
    if (rd_v === 1'b1) rq.push_back(rd_d);
    if (done === 1'b1) begin
      dn = 1;
      nk = nak;
    end
    if (lnk2.done === 1'b1) begin
      dn2 = 1;
      nk2 = lnk2.nak;
    end
    if (cyc == 40000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    lnk2.h2d_valid = 1'b0;
    lnk2.h2d_last = 1'b0;
    lnk2.h2d_data = 8'h00;
    lnk2.rd_req = 1'b0;
    foreach (fac[i]) fac[i] = 8'h00;
    for (int p = 0; p < 8; p++) fac[`CSE_OFS_DRIVE + 7 * p] = 8'hFF;
    fac[`CSE_OFS_DIV] = `CSE_FACT_DIV;
    repeat (6) @(negedge CLK_I);
    SRST_I = 1'b0;
    @(negedge CLK_I);
    chk_img("reset live", fac, live);
    chk("reset source", `CSE_SRC_FACTORY, src);
    $display("test reset done");
    rnd_img();
    op(`CSE_CMD_WR_LIVE);
    livem = img;
    chk_img("live write", livem, live);
    op(`CSE_CMD_RD_LIVE);
    chk_rd(livem);
    rnd_img();
    op(`CSE_CMD_WR_POR);
    stored = img;
    chk_img("live kept", livem, live);
    chk("user valid", 1, eev);
    op(`CSE_CMD_RD_POR);
    chk_rd(stored);
    op(`CSE_CMD_RECONF);
    chk_img("reload", stored, live);
    chk("user source", `CSE_SRC_USER, src);
    rnd_img();
    op(`CSE_CMD_WR_LIVE);
    livem = img;
    op(`CSE_CMD_STORE);
    op(`CSE_CMD_RD_POR);
    chk_rd(livem);
    op(`CSE_CMD_FACTORY);
    chk("user cleared", 0, eev);
    chk_img("live after restore", livem, live);
    op(`CSE_CMD_RD_POR);
    chk_rd(fac);
    op(`CSE_CMD_RECONF);
    chk_img("factory reload", fac, live);
    chk("factory source", `CSE_SRC_FACTORY, src);
    op(8'h08, 1'b1);
    rnd_img();
    raw(8'h30, 8'h05, 146, 1'b1);
    chk("bad crc nak", 1, nk2);
    chk_img("bad image dropped", fac, live_b);
    raw(8'h30, 8'h03, 100, 1'b0);
    chk("short nak", 1, nk2);
    raw(8'h30, 8'h03, 146, 1'b1);
    chk("bad default nak", 1, nk2);
    chk("defaults kept", 0, eev_b);
    raw(8'h30, 8'h08, 0, 1'b0);
    chk("unknown nak", 1, nk2);
    raw(8'h31, 8'h05, 146, 1'b0);
    chk("other addr ack", 0, nk2);
    chk_img("other addr ignored", fac, live_b);
    raw(8'h30, 8'h05, 146, 1'b0);
    chk("good image ack", 0, nk2);
    chk_img("good image live", img, live_b);
    $display("test raw link done");
    end_sim();
  end
endmodule : tb
`default_nettype wire
